//--- design/srr_pkg.sv
// Constants and layouts of the result and unlock register set
// Function
// - Filter configuration is never read directly; host reads memory word 07h.
// - Filter configuration writes only in test mode; memory copy also needs unlock.
// - Offset measure control bit: 0 enables, 1 disables both channels.
// - IR offset averaging bit: 512 when 0, 1024 when 1.
// - Temp offset averaging bit: 512 when 0, 1024 when 1.
// - IR filter depth code 000..100 gives 64..1024 points.
// - Temp filter depth code uses the same 64..1024 encoding.
// - Conversion result readable in every mode, writable only in test mode.
// - Object result: 12-bit data in bits 15:4, status in bits 3:0.
// - Over range sets bit 3 and forces data to all ones.
// - Under range sets bit 2 and forces data to zero.
// - Bit 1 of each result shows an uncorrectable memory fault.
// - Bit 0 of each result always reads zero.
// - Ambient result same layout, status bits equal object status bits.
// - IR data is measured IR minus the IR amplifier offset.
// - Temp data is measured Temp compensated by the Temp amplifier offset.
// - Amplifier offsets stored, compensate each measurement, writable only in test mode.
// - Mode key clears at reset; 1011001 in bits 15:9 enters test mode.
// - Protection key clears at reset, blocks memory writes, never readable.
// - 1100101 in bits 6:0 unlocks memory writes and sets the enable flag.
// - Locations 00-07h and 79-7Fh need test mode as well as unlock.
// - Test and write-enable flags change only through the key registers.
package srr_pkg;
    localparam int unsigned SRR_DW = 16;
    localparam int unsigned SRR_AW = 4;
    localparam int unsigned SRR_MAW = 7;
    // Register indices on the word port
    localparam logic [3:0] SRR_IDX_CONV = 4'h0;
    localparam logic [3:0] SRR_IDX_OBJ = 4'h1;
    localparam logic [3:0] SRR_IDX_AMB = 4'h2;
    localparam logic [3:0] SRR_IDX_IRD = 4'h3;
    localparam logic [3:0] SRR_IDX_TD = 4'h4;
    localparam logic [3:0] SRR_IDX_IROS = 4'h5;
    localparam logic [3:0] SRR_IDX_TOS = 4'h6;
    localparam logic [3:0] SRR_IDX_MAIN = 4'h7;
    localparam logic [3:0] SRR_IDX_MODE = 4'h8;
    localparam logic [3:0] SRR_IDX_UNLK = 4'h9;
    localparam logic [3:0] SRR_IDX_FILT = 4'ha;
    // Key values and filter memory location
    localparam logic [6:0] SRR_MODE_KEY = 7'h59;
    localparam logic [6:0] SRR_UNLK_KEY = 7'h65;
    localparam logic [6:0] SRR_FILT_LOC = 7'h07;
    localparam logic [6:0] SRR_LOW_PROT_HI = 7'h07;
    localparam logic [6:0] SRR_HIGH_PROT_LO = 7'h79;
    // Filter configuration field positions
    localparam int unsigned SRR_F_RSEL = 15;
    localparam int unsigned SRR_F_OSMD = 14;
    localparam int unsigned SRR_F_IROS = 12;
    localparam int unsigned SRR_F_TOS = 11;
    localparam int unsigned SRR_F_IRLO = 8;
    localparam int unsigned SRR_F_TLO = 5;
    // Result status bit positions
    localparam int unsigned SRR_S_OVER = 3;
    localparam int unsigned SRR_S_UNDER = 2;
    localparam int unsigned SRR_S_FATAL = 1;
    // Averaging counts
    localparam logic [10:0] SRR_PTS_64 = 11'h040;
    localparam logic [10:0] SRR_PTS_128 = 11'h080;
    localparam logic [10:0] SRR_PTS_256 = 11'h100;
    localparam logic [10:0] SRR_PTS_512 = 11'h200;
    localparam logic [10:0] SRR_PTS_1024 = 11'h400;
    localparam logic [11:0] SRR_DATA_MAX = 12'hfff;
    localparam logic [11:0] SRR_DATA_MIN = 12'h000;
endpackage

//--- design/srr_regs.sv
// Result, filter configuration and unlock key registers of the sensor conditioner
`timescale 1ns/100ps
`default_nettype none
module srr_regs
    import srr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Word port from the serial frame decoder
    input wire logic [3:0] reg_idx_i,
    input wire logic wr_stb_i,
    input wire logic [15:0] wdata_i,
    input wire logic rd_stb_i,
    output logic [15:0] rdata_o,
    output logic rd_valid_o,
    output logic rd_err_o,
    output logic wr_err_o,
    // Filter configuration load from memory at start-up
    input wire logic filt_load_i,
    input wire logic [15:0] filt_load_data_i,
    // Measurement path
    input wire logic conv_stb_i,
    input wire logic [15:0] conv_data_i,
    input wire logic obj_stb_i,
    input wire logic [11:0] obj_temp_i,
    input wire logic obj_over_i,
    input wire logic obj_under_i,
    input wire logic amb_stb_i,
    input wire logic [11:0] amb_temp_i,
    input wire logic amb_over_i,
    input wire logic amb_under_i,
    input wire logic ir_stb_i,
    input wire logic [15:0] ir_raw_i,
    input wire logic t_stb_i,
    input wire logic [15:0] t_raw_i,
    input wire logic iros_stb_i,
    input wire logic [15:0] iros_data_i,
    input wire logic tos_stb_i,
    input wire logic [15:0] tos_data_i,
    input wire logic mem_fatal_i,
    // Memory write permission
    input wire logic mem_wr_req_i,
    input wire logic [6:0] mem_addr_i,
    output logic mem_wr_grant_o,
    output logic mem_wr_deny_o,
    // Status flags and filter settings
    output logic test_mode_o,
    output logic memory_write_enabled_flag_o,
    output logic adc_range_select_msb_o,
    output logic offset_measure_en_o,
    output logic [10:0] ir_offset_avg_o,
    output logic [10:0] temp_offset_avg_o,
    output logic [10:0] ir_filter_points_o,
    output logic [10:0] temp_filter_points_o,
    output logic [15:0] main_state_o
);
    logic [15:0] conversion_result;
    logic [11:0] object_data;
    logic [11:0] ambient_data;
    logic [3:0] result_status;
    logic [15:0] ir_compensated_data;
    logic [15:0] temp_compensated_data;
    logic [15:0] ir_amp_offset;
    logic [15:0] temp_amp_offset;
    logic wr_obj;
    logic wr_amb;
    logic next_test;
    logic next_unlock;
    logic filt_we;
    logic [15:0] filt_word;
    logic readable;
    logic [15:0] next_rdata;
    logic mem_prot_area;

    // Averaging depth code to number of points; unused codes saturate at 1024
    function automatic logic [10:0] depth_points(input logic [2:0] code);
        logic [10:0] pts;
        pts = SRR_PTS_1024;
        unique case (code)
            3'h0: pts = SRR_PTS_64;
            3'h1: pts = SRR_PTS_128;
            3'h2: pts = SRR_PTS_256;
            3'h3: pts = SRR_PTS_512;
            default: pts = SRR_PTS_1024;
        endcase
        return pts;
    endfunction

    // Key decode, evaluated on the written word
    assign next_test = (wdata_i[15:9] == SRR_MODE_KEY);
    assign next_unlock = (wdata_i[6:0] == SRR_UNLK_KEY);
    assign wr_obj = wr_stb_i && test_mode_o && (reg_idx_i == SRR_IDX_OBJ);
    assign wr_amb = wr_stb_i && test_mode_o && (reg_idx_i == SRR_IDX_AMB);

    // Mode key: any write re-decodes; only the key gives test mode
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            test_mode_o <= 1'b0;
        end else if (wr_stb_i && reg_idx_i == SRR_IDX_MODE) begin
            test_mode_o <= next_test;
        end
    end

    // Protection key: cleared at reset so memory starts locked
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            memory_write_enabled_flag_o <= 1'b0;
        end else if (wr_stb_i && reg_idx_i == SRR_IDX_UNLK) begin
            memory_write_enabled_flag_o <= next_unlock;
        end
    end

    // Filter configuration: start-up copy or a test-mode write
    assign filt_we = wr_stb_i && test_mode_o && (reg_idx_i == SRR_IDX_FILT);
    assign filt_word = filt_we ? wdata_i : filt_load_data_i;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            adc_range_select_msb_o <= 1'b0;
            offset_measure_en_o <= 1'b1;
            ir_offset_avg_o <= SRR_PTS_512;
            temp_offset_avg_o <= SRR_PTS_512;
            ir_filter_points_o <= SRR_PTS_64;
            temp_filter_points_o <= SRR_PTS_64;
        end else if (filt_we || filt_load_i) begin
            adc_range_select_msb_o <= filt_word[SRR_F_RSEL];
            offset_measure_en_o <= ~filt_word[SRR_F_OSMD];
            ir_offset_avg_o <= filt_word[SRR_F_IROS] ? SRR_PTS_1024 : SRR_PTS_512;
            temp_offset_avg_o <= filt_word[SRR_F_TOS] ? SRR_PTS_1024 : SRR_PTS_512;
            ir_filter_points_o <= depth_points(filt_word[SRR_F_IRLO +: 3]);
            temp_filter_points_o <= depth_points(filt_word[SRR_F_TLO +: 3]);
        end
    end

    // Conversion result; a test-mode write wins over a new sample
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            conversion_result <= 16'h0000;
        end else if (wr_stb_i && test_mode_o && reg_idx_i == SRR_IDX_CONV) begin
            conversion_result <= wdata_i;
        end else if (conv_stb_i) begin
            conversion_result <= conv_data_i;
        end
    end

    // Object data, clamped by the range flags
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            object_data <= 12'h000;
        end else if (wr_obj) begin
            object_data <= wdata_i[15:4];
        end else if (obj_stb_i) begin
            if (obj_over_i) begin
                object_data <= SRR_DATA_MAX;
            end else if (obj_under_i) begin
                object_data <= SRR_DATA_MIN;
            end else begin
                object_data <= obj_temp_i;
            end
        end
    end

    // Ambient data, same clamping
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ambient_data <= 12'h000;
        end else if (wr_amb) begin
            ambient_data <= wdata_i[15:4];
        end else if (amb_stb_i) begin
            if (amb_over_i) begin
                ambient_data <= SRR_DATA_MAX;
            end else if (amb_under_i) begin
                ambient_data <= SRR_DATA_MIN;
            end else begin
                ambient_data <= amb_temp_i;
            end
        end
    end

    // One status nibble shared by both results; latest update owns it, ambient over object in one cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_status <= 4'h0;
        end else begin
            result_status[SRR_S_FATAL] <= mem_fatal_i;
            result_status[0] <= 1'b0;
            if (wr_obj || wr_amb) begin
                result_status[SRR_S_OVER] <= wdata_i[SRR_S_OVER];
                result_status[SRR_S_UNDER] <= wdata_i[SRR_S_UNDER];
            end else if (amb_stb_i) begin
                result_status[SRR_S_OVER] <= amb_over_i;
                result_status[SRR_S_UNDER] <= amb_under_i && !amb_over_i;
            end else if (obj_stb_i) begin
                result_status[SRR_S_OVER] <= obj_over_i;
                result_status[SRR_S_UNDER] <= obj_under_i && !obj_over_i;
            end
        end
    end

    // Amplifier offsets from the offset measurement or test-mode write
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ir_amp_offset <= 16'h0000;
            temp_amp_offset <= 16'h0000;
        end else begin
            if (wr_stb_i && test_mode_o && reg_idx_i == SRR_IDX_IROS) begin
                ir_amp_offset <= wdata_i;
            end else if (iros_stb_i) begin
                ir_amp_offset <= iros_data_i;
            end
            if (wr_stb_i && test_mode_o && reg_idx_i == SRR_IDX_TOS) begin
                temp_amp_offset <= wdata_i;
            end else if (tos_stb_i) begin
                temp_amp_offset <= tos_data_i;
            end
        end
    end

    // Compensated data uses the offset held before this edge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ir_compensated_data <= 16'h0000;
            temp_compensated_data <= 16'h0000;
        end else begin
            if (wr_stb_i && test_mode_o && reg_idx_i == SRR_IDX_IRD) begin
                ir_compensated_data <= wdata_i;
            end else if (ir_stb_i) begin
                ir_compensated_data <= ir_raw_i - ir_amp_offset;
            end
            if (wr_stb_i && test_mode_o && reg_idx_i == SRR_IDX_TD) begin
                temp_compensated_data <= wdata_i;
            end else if (t_stb_i) begin
                temp_compensated_data <= t_raw_i - temp_amp_offset;
            end
        end
    end

    // Reserved state word, write-only in test mode
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            main_state_o <= 16'h0000;
        end else if (wr_stb_i && test_mode_o && reg_idx_i == SRR_IDX_MAIN) begin
            main_state_o <= wdata_i;
        end
    end

    // Read mux; key, filter and reserved words answer zero with an error
    always_comb begin
        readable = 1'b1;
        next_rdata = 16'h0000;
        unique case (reg_idx_i)
            SRR_IDX_CONV: next_rdata = conversion_result;
            SRR_IDX_OBJ: next_rdata = {object_data, result_status};
            SRR_IDX_AMB: next_rdata = {ambient_data, result_status};
            SRR_IDX_IRD: next_rdata = ir_compensated_data;
            SRR_IDX_TD: next_rdata = temp_compensated_data;
            SRR_IDX_IROS: next_rdata = ir_amp_offset;
            SRR_IDX_TOS: next_rdata = temp_amp_offset;
            default: readable = 1'b0;
        endcase
    end

    // Read answer one cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 16'h0000;
            rd_valid_o <= 1'b0;
            rd_err_o <= 1'b0;
        end else begin
            rd_valid_o <= rd_stb_i;
            rd_err_o <= rd_stb_i && !readable;
            if (rd_stb_i) begin
                rdata_o <= readable ? next_rdata : 16'h0000;
            end
        end
    end

    // Writes outside test mode to protected words are flagged, not stored
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_err_o <= 1'b0;
        end else begin
            wr_err_o <= wr_stb_i && !test_mode_o
                && reg_idx_i != SRR_IDX_MODE && reg_idx_i != SRR_IDX_UNLK;
        end
    end

    // Memory write permission; edge areas also need test mode
    assign mem_prot_area = (mem_addr_i <= SRR_LOW_PROT_HI) || (mem_addr_i >= SRR_HIGH_PROT_LO);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_wr_grant_o <= 1'b0;
            mem_wr_deny_o <= 1'b0;
        end else begin
            mem_wr_grant_o <= mem_wr_req_i && memory_write_enabled_flag_o
                && (test_mode_o || !mem_prot_area);
            mem_wr_deny_o <= mem_wr_req_i && !(memory_write_enabled_flag_o
                && (test_mode_o || !mem_prot_area));
        end
    end

    // Checks
    a_test_key_entry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_stb_i && reg_idx_i == SRR_IDX_MODE |=> test_mode_o == $past(next_test))
        else $error("test mode does not follow mode key");
    a_flags_stable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !(wr_stb_i && (reg_idx_i == SRR_IDX_MODE || reg_idx_i == SRR_IDX_UNLK))
        |=> $stable(test_mode_o) && $stable(memory_write_enabled_flag_o))
        else $error("status flag changed without key write");
    a_unlock_key: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_stb_i && reg_idx_i == SRR_IDX_UNLK && wdata_i[6:0] == SRR_UNLK_KEY
        |=> memory_write_enabled_flag_o)
        else $error("unlock key not honoured");
    a_edge_protect: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        mem_wr_req_i && !test_mode_o && (mem_addr_i <= SRR_FILT_LOC || mem_addr_i >= SRR_HIGH_PROT_LO)
        |=> !mem_wr_grant_o && mem_wr_deny_o)
        else $error("protected memory location granted");
    a_filter_locked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_stb_i && !test_mode_o && !filt_load_i && reg_idx_i == SRR_IDX_FILT
        |=> $stable(ir_filter_points_o) && $stable(offset_measure_en_o))
        else $error("filter configuration written outside test mode");
    a_filter_unread: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_stb_i && reg_idx_i == SRR_IDX_FILT |=> rd_err_o && rdata_o == 16'h0000)
        else $error("filter configuration was readable");
    a_over_clamp: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        obj_stb_i && obj_over_i && !wr_obj && !wr_amb && !amb_stb_i
        |=> object_data == SRR_DATA_MAX && result_status[SRR_S_OVER])
        else $error("over range not clamped");
    a_zero_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_valid_o && !rd_err_o && $past(reg_idx_i == SRR_IDX_AMB) |-> !rdata_o[0])
        else $error("result bit 0 not zero");
    a_ir_comp: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ir_stb_i && !wr_stb_i |=> ir_compensated_data == 16'($past(ir_raw_i) - $past(ir_amp_offset)))
        else $error("IR data not offset compensated");
    a_depth_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        filt_load_i && !filt_we && filt_load_data_i[SRR_F_IRLO +: 3] == 3'h3
        |=> ir_filter_points_o == SRR_PTS_512)
        else $error("IR depth code 011 not 512 points");

    // Result path, key and permission checks; read-back fatal bit lags its pin by two cycles
    a_under_clamp: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        amb_stb_i && amb_under_i && !amb_over_i && !wr_obj && !wr_amb
        |=> ambient_data == SRR_DATA_MIN && result_status[SRR_S_UNDER])
        else $error("under range not clamped");
    a_fatal_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_valid_o && !rd_err_o && ($past(reg_idx_i) == SRR_IDX_OBJ || $past(reg_idx_i) == SRR_IDX_AMB)
        |-> rdata_o[SRR_S_FATAL] == $past(mem_fatal_i, 2))
        else $error("fatal bit does not mirror memory fault");
    a_conv_locked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_stb_i && !test_mode_o && !conv_stb_i && reg_idx_i == SRR_IDX_CONV
        |=> $stable(conversion_result) && wr_err_o)
        else $error("conversion result written outside test mode");
    a_temp_comp: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        t_stb_i && !wr_stb_i
        |=> temp_compensated_data == 16'($past(t_raw_i) - $past(temp_amp_offset)))
        else $error("Temp data not offset compensated");
    a_unlock_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_stb_i && reg_idx_i == SRR_IDX_UNLK && wdata_i[6:0] != SRR_UNLK_KEY
        |=> !memory_write_enabled_flag_o)
        else $error("protection not restored by other value");
    a_grant_open: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        mem_wr_req_i && memory_write_enabled_flag_o && mem_addr_i > SRR_LOW_PROT_HI
        && mem_addr_i < SRR_HIGH_PROT_LO |=> mem_wr_grant_o)
        else $error("unlocked memory location denied");

    // Main scenarios reached
    c_test_write: cover property (@(posedge clk_i) disable iff (!rst_n_i) wr_obj || wr_amb);
    c_enter_test: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(test_mode_o));
    c_grant: cover property (@(posedge clk_i) disable iff (!rst_n_i) mem_wr_grant_o);
    c_under: cover property (@(posedge clk_i) disable iff (!rst_n_i) amb_stb_i && amb_under_i);
    c_read_err: cover property (@(posedge clk_i) disable iff (!rst_n_i) rd_err_o);
endmodule
`default_nettype wire

//--- tb/srr_host_model.sv
// Behavioural serial host that moves whole register words
`timescale 1ns/100ps
`default_nettype none
module srr_host_model
    import srr_pkg::*;
(
    input wire logic clk_i,
    output logic [3:0] reg_idx_o,
    output logic wr_stb_o,
    output logic [15:0] wdata_o,
    output logic rd_stb_o,
    input wire logic [15:0] rdata_i,
    input wire logic rd_valid_i,
    input wire logic rd_err_i,
    input wire logic wr_err_i
);
    // Idle at time zero
    initial begin
        reg_idx_o = 4'h0;
        wr_stb_o = 1'b0;
        wdata_o = 16'h0000;
        rd_stb_o = 1'b0;
    end
    // One word per write; reserved averaging bit always sent clear
    task automatic wr(input logic [3:0] idx, input logic [15:0] d, output logic err);
        @(posedge clk_i) #1;
        reg_idx_o = idx;
        wdata_o = (idx == SRR_IDX_FILT) ? (d & 16'hdfff) : d;
        wr_stb_o = 1'b1;
        @(posedge clk_i) #1;
        wr_stb_o = 1'b0;
        err = wr_err_i;
        // Released lines toggle so a stale word is never taken as held
        reg_idx_o = ~idx;
        wdata_o = ~wdata_o;
    endtask
    // One word per read, answer taken one edge after the request
    task automatic rd(input logic [3:0] idx, output logic [15:0] d, output logic v, output logic e);
        @(posedge clk_i) #1;
        reg_idx_o = idx;
        rd_stb_o = 1'b1;
        @(posedge clk_i) #1;
        rd_stb_o = 1'b0;
        d = rdata_i;
        v = rd_valid_i;
        e = rd_err_i;
        reg_idx_o = ~idx;
    endtask
endmodule
`default_nettype wire

//--- tb/tb_sensor_result_and_unlock_regs.sv
// Self-checking bench for the result and unlock register set
`timescale 1ns/100ps
`default_nettype none
module tb_sensor_result_and_unlock_regs;
    import srr_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] reg_idx;
    logic wr_stb, rd_stb, rd_valid, rd_err, wr_err, test_mode, mwe, osm_en, rsel, grant, deny, e;
    logic [15:0] wdata, rdata, main_state;
    logic filt_load = 0, conv_stb = 0, obj_stb = 0, amb_stb = 0, ir_stb = 0, t_stb = 0, iros_stb = 0;
    logic tos_stb = 0, obj_over = 0, obj_under = 0, amb_over = 0, amb_under = 0, mem_fatal = 0, mreq_s = 0;
    logic [15:0] filt_data = 0, conv_data = 0, ir_raw = 0, t_raw = 0, iros_data = 0, tos_data = 0;
    logic [11:0] obj_temp = 0, amb_temp = 0;
    logic [6:0] mem_addr = 0;
    logic [10:0] ir_avg, t_avg, ir_pts, t_pts;
    int err_total = 0;
    int checks_done = 0;
    // Free-running 200 MHz clock
    always #2.5 clk_i = ~clk_i;
    srr_host_model u_srr_host_model (.clk_i(clk_i), .reg_idx_o(reg_idx), .wr_stb_o(wr_stb), .wdata_o(wdata),
        .rd_stb_o(rd_stb), .rdata_i(rdata), .rd_valid_i(rd_valid), .rd_err_i(rd_err), .wr_err_i(wr_err));
    srr_regs u_srr_regs (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_idx_i(reg_idx), .wr_stb_i(wr_stb),
        .wdata_i(wdata), .rd_stb_i(rd_stb), .rdata_o(rdata), .rd_valid_o(rd_valid), .rd_err_o(rd_err),
        .wr_err_o(wr_err), .filt_load_i(filt_load), .filt_load_data_i(filt_data), .conv_stb_i(conv_stb),
        .conv_data_i(conv_data), .obj_stb_i(obj_stb), .obj_temp_i(obj_temp), .obj_over_i(obj_over),
        .obj_under_i(obj_under), .amb_stb_i(amb_stb), .amb_temp_i(amb_temp), .amb_over_i(amb_over),
        .amb_under_i(amb_under), .ir_stb_i(ir_stb), .ir_raw_i(ir_raw), .t_stb_i(t_stb), .t_raw_i(t_raw),
        .iros_stb_i(iros_stb), .iros_data_i(iros_data), .tos_stb_i(tos_stb), .tos_data_i(tos_data),
        .mem_fatal_i(mem_fatal), .mem_wr_req_i(mreq_s), .mem_addr_i(mem_addr), .mem_wr_grant_o(grant),
        .mem_wr_deny_o(deny), .test_mode_o(test_mode), .memory_write_enabled_flag_o(mwe),
        .adc_range_select_msb_o(rsel), .offset_measure_en_o(osm_en), .ir_offset_avg_o(ir_avg),
        .temp_offset_avg_o(t_avg), .ir_filter_points_o(ir_pts), .temp_filter_points_o(t_pts),
        .main_state_o(main_state));
    task automatic tick;
        @(posedge clk_i) #1;
    endtask
    // Strobes last exactly one taking edge
    task automatic drop;
        tick;
        {filt_load, conv_stb, obj_stb, amb_stb, ir_stb, t_stb, iros_stb, tos_stb, mreq_s} = '0;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wchk(input logic [3:0] idx, input logic [15:0] d, input logic xerr);
        u_srr_host_model.wr(idx, d, e);
        chk(16'(e), 16'(xerr));
    endtask
    task automatic rchk(input logic [3:0] idx, input logic [15:0] exp, input logic xerr);
        logic [15:0] d;
        logic v, re;
        u_srr_host_model.rd(idx, d, v, re);
        chk({14'h0, v, re}, {15'h1, xerr});
        chk(d, exp);
    endtask
    task automatic mchk(input logic [6:0] a, input logic ok);
        tick;
        mem_addr = a;
        mreq_s = 1'b1;
        drop;
        chk({14'h0, grant, deny}, ok ? 16'h0002 : 16'h0001);
    endtask
    task automatic s_reset;
        chk({13'h0, test_mode, mwe, osm_en}, 16'h0001);
        chk({5'h0, ir_pts}, 16'h0040);
        chk({5'h0, t_avg}, 16'h0200);
    endtask
    task automatic s_normal;
        tick;
        conv_data = 16'h0abc;
        conv_stb = 1'b1;
        drop;
        rchk(SRR_IDX_CONV, 16'h0abc, 0);
        wchk(SRR_IDX_CONV, 16'h1111, 1);
        rchk(SRR_IDX_CONV, 16'h0abc, 0);
        wchk(SRR_IDX_FILT, 16'h0400, 1);
        chk({5'h0, ir_pts}, 16'h0040);
        wchk(SRR_IDX_IROS, 16'h0001, 1);
        rchk(SRR_IDX_FILT, 16'h0000, 1);
        rchk(SRR_IDX_MODE, 16'h0000, 1);
        rchk(SRR_IDX_UNLK, 16'h0000, 1);
        wchk(SRR_IDX_MODE, 16'h00b2, 0);
        chk(16'(test_mode), 16'h0000);
        wchk(SRR_IDX_MODE, {SRR_MODE_KEY, 9'h1ff}, 0);
        chk({14'h0, test_mode, mwe}, 16'h0002);
    endtask
    task automatic s_filter;
        for (int k = 0; k < 5; k++) begin
            wchk(SRR_IDX_FILT, {k[1], k[0], 1'b0, k[1], ~k[1], 3'(k), 3'(4 - k), 5'h00}, 0);
            chk({5'h0, ir_pts}, 16'h0040 << k);
            chk({5'h0, t_pts}, 16'h0040 << (4 - k));
            chk({14'h0, rsel, osm_en}, {14'h0, k[1], !k[0]});
            chk({5'h0, ir_avg}, k[1] ? 16'h0400 : 16'h0200);
            chk({5'h0, t_avg}, k[1] ? 16'h0200 : 16'h0400);
        end
        tick;
        filt_data = 16'h0300;
        filt_load = 1'b1;
        drop;
        chk({5'h0, ir_pts}, 16'h0200);
    endtask
    task automatic s_results;
        tick;
        mem_fatal = 1'b1;
        {obj_temp, obj_over, obj_stb} = {12'h123, 2'b11};
        drop;
        rchk(SRR_IDX_OBJ, 16'hfffa, 0);
        tick;
        {amb_temp, amb_under, amb_stb, obj_over} = {12'h456, 3'b110};
        drop;
        rchk(SRR_IDX_AMB, 16'h0006, 0);
        rchk(SRR_IDX_OBJ, 16'hfff6, 0);
        mem_fatal = 1'b0;
        wchk(SRR_IDX_OBJ, 16'h5679, 0);
        rchk(SRR_IDX_OBJ, 16'h5678, 0);
        rchk(SRR_IDX_AMB, 16'h0008, 0);
    endtask
    task automatic s_comp;
        tick;
        {iros_data, iros_stb, tos_data, tos_stb} = {16'h0010, 1'b1, 16'h0100, 1'b1};
        drop;
        tick;
        {ir_raw, ir_stb, t_raw, t_stb} = {16'h0005, 1'b1, 16'h1234, 1'b1};
        drop;
        rchk(SRR_IDX_IRD, 16'hfff5, 0);
        rchk(SRR_IDX_TD, 16'h1134, 0);
        rchk(SRR_IDX_IROS, 16'h0010, 0);
        wchk(SRR_IDX_TOS, 16'h0001, 0);
        tick;
        {t_raw, t_stb} = {16'h0003, 1'b1};
        drop;
        rchk(SRR_IDX_TD, 16'h0002, 0);
        wchk(SRR_IDX_MAIN, 16'h5a5a, 0);
        chk(main_state, 16'h5a5a);
    endtask
    task automatic s_unlock;
        logic [6:0] adr [6] = '{7'h00, 7'h07, 7'h08, 7'h78, 7'h79, 7'h7f};
        mchk(7'h08, 0);
        wchk(SRR_IDX_UNLK, 16'hff65, 0);
        chk(16'(mwe), 16'h0001);
        for (int i = 0; i < 6; i++) mchk(adr[i], 1);
        wchk(SRR_IDX_MODE, 16'h0000, 0);
        chk({14'h0, test_mode, mwe}, 16'h0001);
        for (int i = 0; i < 6; i++) mchk(adr[i], i == 2 || i == 3);
        wchk(SRR_IDX_UNLK, 16'h0066, 0);
        chk(16'(mwe), 16'h0000);
        mchk(7'h08, 0);
    endtask
    task automatic end_of_test;
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Main sequence after a 20-cycle reset
    initial begin
        repeat (20) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        s_reset;
        s_normal;
        s_filter;
        s_results;
        s_comp;
        s_unlock;
        end_of_test;
    end
    // Watchdog; the whole run needs well under 600 cycles
    initial begin
        #15000;
        err_total++;
        end_of_test;
    end
endmodule
`default_nettype wire
